// ---- include/scr_pkg.sv ----
package scr_pkg;

  // Register offsets on the byte-wide register port
  localparam logic [7:0] SCR_OFF_CONFIG  = 8'h40;
  localparam logic [7:0] SCR_OFF_ADDRESS = 8'h43;
  localparam logic [7:0] SCR_OFF_PUNIT   = 8'h44;
  localparam logic [7:0] SCR_OFF_PFRAC   = 8'h47;
  localparam logic [7:0] SCR_OFF_TUNIT   = 8'h4D;
  localparam logic [7:0] SCR_OFF_TFRAC   = 8'h50;

  // Configuration register fields
  localparam int         SCR_CFG_APPLY_BIT = 7;
  localparam int         SCR_CFG_TYPE_BIT  = 0;
  localparam logic [7:0] SCR_CFG_KEEP_MASK = 8'h1F;
  localparam logic [7:0] SCR_CFG_RESET     = 8'h00;

  // Address register field: bits 7..1 hold the address, bit 0 is ignored
  localparam int         SCR_ADDR_LSB      = 1;
  localparam logic [6:0] SCR_ADDR_RESET    = 7'h28;  // Arbitrary default

  // Unit codes
  localparam logic [7:0] SCR_PUNIT_RESET = 8'h07;
  localparam logic [7:0] SCR_TUNIT_RESET = 8'h20;
  localparam logic [7:0] SCR_PUNIT_A_LO  = 8'h01;
  localparam logic [7:0] SCR_PUNIT_A_HI  = 8'h0E;
  localparam logic [7:0] SCR_PUNIT_B     = 8'h91;
  localparam logic [7:0] SCR_PUNIT_C_LO  = 8'hAA;
  localparam logic [7:0] SCR_PUNIT_C_HI  = 8'hAE;
  localparam logic [7:0] SCR_PUNIT_D_LO  = 8'hB0;
  localparam logic [7:0] SCR_PUNIT_D_HI  = 8'hB3;
  localparam logic [7:0] SCR_PUNIT_E_LO  = 8'hED;
  localparam logic [7:0] SCR_PUNIT_E_HI  = 8'hEF;
  localparam logic [7:0] SCR_TUNIT_LO    = 8'h20;
  localparam logic [7:0] SCR_TUNIT_HI    = 8'h23;

  // Fraction digit calculation
  localparam logic [7:0]  SCR_FRAC_INVALID = 8'hFF;
  localparam int          SCR_FRAC_MAX     = 5;
  localparam logic [35:0] SCR_INT16_MAX    = 36'h0_0000_7FFF;
  localparam logic [7:0]  SCR_READ_ZERO    = 8'h00;

  // Register request from the bus engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] off;
    logic [7:0] wdata;
  } scr_req_t;

  // Answer to a register request
  typedef struct packed {
    logic       done;
    logic       ack;
    logic [7:0] rdata;
  } scr_rsp_t;

endpackage

// ---- rtl/scr_frac_digits.sv ----
module scr_frac_digits (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rstn,
  // Nominal range, signed, in units of 10^-4 so that ends beyond 32767 can be expressed
  input  wire logic signed [31:0] range_lo,
  input  wire logic signed [31:0] range_hi,
  // Fraction digit count
  output logic         [7:0]      digits_q
);
  import scr_pkg::*;

  typedef struct packed {
    logic [7:0] digits;
  } scr_fd_state_t;

  scr_fd_state_t st_q;
  scr_fd_state_t st_d;

  // Magnitude of a signed range end
  function automatic logic [35:0] mag(input logic signed [31:0] v);
    logic [32:0] w;
    w = {v[31], v};
    if (v[31]) begin
      w = -w;
    end
    return {3'h0, w};
  endfunction

  // Largest value shown with d digits, in 10^-4 units: 32767 * 10^(5-d) / 10, rounded down
  function automatic logic [35:0] limit(input int d);
    logic [35:0] l;
    l = SCR_INT16_MAX;
    for (int i = 0; i < SCR_FRAC_MAX; i++) begin
      if (i < SCR_FRAC_MAX - d) begin
        l = 36'(l * 36'hA);
      end
    end
    l = l / 36'hA;  // Input scale is one decade coarser than the fifth digit
    return l;
  endfunction

  // Pick the most digits that still fit in a 16-bit integer
  always_comb begin
    logic [35:0] m;
    m = mag(range_lo);
    if (mag(range_hi) > m) begin
      m = mag(range_hi);
    end
    st_d.digits = SCR_FRAC_INVALID;
    for (int d = 0; d <= SCR_FRAC_MAX; d++) begin
      if (m <= limit(d)) begin
        st_d.digits = 8'(d);
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{digits: SCR_FRAC_INVALID};
    end else begin
      st_q <= st_d;
    end
  end

  assign digits_q = st_q.digits;

endmodule

// ---- rtl/scr_config_regs.sv ----
module scr_config_regs (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rstn,
  // Register requests from the bus engine
  input  scr_pkg::scr_req_t       req,
  output scr_pkg::scr_rsp_t       rsp_q,
  // Address match query
  input  wire logic               match_stb,
  input  wire logic        [6:0]  match_addr,
  output logic                    addr_match_q,
  // Nominal ranges from the rest of the unit
  input  wire logic signed [31:0] p_range_lo,
  input  wire logic signed [31:0] p_range_hi,
  input  wire logic signed [31:0] t_range_lo,
  input  wire logic signed [31:0] t_range_hi,
  // Settings towards the rest of the unit
  output logic             [6:0]  live_address_q,
  output logic             [7:0]  config_q,
  output logic             [7:0]  pressure_unit_q,
  output logic             [7:0]  temperature_unit_q,
  output logic                    fault_flag_q
);
  import scr_pkg::*;

  typedef struct packed {
    logic [6:0] live;
    logic [7:0] addr_reg;
    logic [7:0] cfg;
    logic [7:0] punit;
    logic [7:0] tunit;
    scr_rsp_t   rsp;
    logic       match;
    logic       fault;
  } scr_state_t;

  scr_state_t st_q;
  scr_state_t st_d;
  logic [7:0] pfrac;
  logic [7:0] tfrac;

  // Valid pressure unit codes
  function automatic logic punit_ok(input logic [7:0] c);
    return (c >= SCR_PUNIT_A_LO && c <= SCR_PUNIT_A_HI) || c == SCR_PUNIT_B ||
           (c >= SCR_PUNIT_C_LO && c <= SCR_PUNIT_C_HI) ||
           (c >= SCR_PUNIT_D_LO && c <= SCR_PUNIT_D_HI) ||
           (c >= SCR_PUNIT_E_LO && c <= SCR_PUNIT_E_HI);
  endfunction

  // Valid temperature unit codes
  function automatic logic tunit_ok(input logic [7:0] c);
    return c >= SCR_TUNIT_LO && c <= SCR_TUNIT_HI;
  endfunction

  // Fraction digit calculators
  scr_frac_digits u_pfrac (
    .clock    (clock),
    .rstn     (rstn),
    .range_lo (p_range_lo),
    .range_hi (p_range_hi),
    .digits_q (pfrac)
  );

  scr_frac_digits u_tfrac (
    .clock    (clock),
    .rstn     (rstn),
    .range_lo (t_range_lo),
    .range_hi (t_range_hi),
    .digits_q (tfrac)
  );

  // Register writes, reads, address match and fault
  always_comb begin
    st_d          = st_q;
    st_d.rsp      = '{done: req.wr | req.rd, ack: 1'b0, rdata: SCR_READ_ZERO};
    st_d.match    = match_stb && match_addr == st_q.live;
    if (req.wr) begin
      case (req.off)
        SCR_OFF_ADDRESS: begin
          st_d.addr_reg = req.wdata;
          st_d.rsp.ack  = 1'b1;
        end
        SCR_OFF_CONFIG: begin
          st_d.cfg     = req.wdata & SCR_CFG_KEEP_MASK;
          st_d.rsp.ack = 1'b1;
          if (req.wdata[SCR_CFG_APPLY_BIT]) begin
            st_d.live = st_q.addr_reg[7:SCR_ADDR_LSB];
          end
        end
        SCR_OFF_PUNIT: begin
          if (punit_ok(req.wdata)) begin
            st_d.punit   = req.wdata;
            st_d.rsp.ack = 1'b1;
          end
        end
        SCR_OFF_TUNIT: begin
          if (tunit_ok(req.wdata)) begin
            st_d.tunit   = req.wdata;
            st_d.rsp.ack = 1'b1;
          end
        end
        default: begin
          st_d.rsp.ack = 1'b0;
        end
      endcase
    end else if (req.rd) begin
      st_d.rsp.ack = 1'b1;
      case (req.off)
        SCR_OFF_ADDRESS: st_d.rsp.rdata = st_q.addr_reg;
        SCR_OFF_CONFIG:  st_d.rsp.rdata = st_q.cfg;
        SCR_OFF_PUNIT:   st_d.rsp.rdata = st_q.punit;
        SCR_OFF_TUNIT:   st_d.rsp.rdata = st_q.tunit;
        SCR_OFF_PFRAC:   st_d.rsp.rdata = pfrac;
        SCR_OFF_TFRAC:   st_d.rsp.rdata = tfrac;
        default:         st_d.rsp.ack = 1'b0;
      endcase
    end
    // Fault follows the current range and mode, so it clears once the range is fixed or float mode is set
    st_d.fault = st_q.cfg[SCR_CFG_TYPE_BIT] &&
                 (pfrac == SCR_FRAC_INVALID || tfrac == SCR_FRAC_INVALID);
  end

  // State register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{live: SCR_ADDR_RESET, addr_reg: {SCR_ADDR_RESET, 1'b0}, cfg: SCR_CFG_RESET,
                punit: SCR_PUNIT_RESET, tunit: SCR_TUNIT_RESET,
                rsp: '{done: 1'b0, ack: 1'b0, rdata: SCR_READ_ZERO}, match: 1'b0, fault: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign rsp_q              = st_q.rsp;
  assign addr_match_q       = st_q.match;
  assign live_address_q     = st_q.live;
  assign config_q           = st_q.cfg;
  assign pressure_unit_q    = st_q.punit;
  assign temperature_unit_q = st_q.tunit;
  assign fault_flag_q       = st_q.fault;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_match;
    match_stb && match_addr == live_address_q |=> addr_match_q;
  endproperty
  a_match: assert property (p_match) else $error("live address not matched");

  property p_addr_wait;
    req.wr && req.off == SCR_OFF_ADDRESS |=> $stable(live_address_q);
  endproperty
  a_addr_wait: assert property (p_addr_wait) else $error("address applied without apply bit");

  property p_apply;
    req.wr && req.off == SCR_OFF_CONFIG && req.wdata[SCR_CFG_APPLY_BIT]
      |=> live_address_q == $past(st_q.addr_reg[7:SCR_ADDR_LSB]);
  endproperty
  a_apply: assert property (p_apply) else $error("pending address not applied");

  property p_punit;
    req.wr && req.off == SCR_OFF_PUNIT && punit_ok(req.wdata)
      |=> rsp_q.ack && pressure_unit_q == $past(req.wdata);
  endproperty
  a_punit: assert property (p_punit) else $error("valid pressure unit not taken");

  property p_tunit_range;
    tunit_ok(temperature_unit_q);
  endproperty
  a_tunit_range: assert property (p_tunit_range) else $error("temperature unit out of set");

  property p_nack;
    req.wr && ((req.off == SCR_OFF_PUNIT && !punit_ok(req.wdata)) ||
               (req.off == SCR_OFF_TUNIT && !tunit_ok(req.wdata)))
      |=> rsp_q.done && !rsp_q.ack && $stable(pressure_unit_q) && $stable(temperature_unit_q);
  endproperty
  a_nack: assert property (p_nack) else $error("invalid unit acknowledged");

  property p_fault_set;
    config_q[SCR_CFG_TYPE_BIT] && (pfrac == SCR_FRAC_INVALID || tfrac == SCR_FRAC_INVALID) |=> fault_flag_q;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not raised");

  property p_float_nofault;
    !config_q[SCR_CFG_TYPE_BIT] |=> !fault_flag_q;
  endproperty
  a_float_nofault: assert property (p_float_nofault) else $error("fault in float mode");

  property p_fault_hold;
    $fell(fault_flag_q) |-> $past(!config_q[SCR_CFG_TYPE_BIT] ||
                                  (pfrac != SCR_FRAC_INVALID && tfrac != SCR_FRAC_INVALID));
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault cleared while range bad");

  property p_frac_read;
    req.rd && !req.wr && req.off == SCR_OFF_PFRAC |=> rsp_q.ack && rsp_q.rdata == $past(pfrac);
  endproperty
  a_frac_read: assert property (p_frac_read) else $error("pressure digits read wrong");

  property p_fault_level;
    fault_flag_q |-> $past(config_q[SCR_CFG_TYPE_BIT]);
  endproperty
  a_fault_level: assert property (p_fault_level) else $error("fault without integer mode");

  c_apply: cover property (req.wr && req.off == SCR_OFF_CONFIG && req.wdata[SCR_CFG_APPLY_BIT]);
  c_nack:  cover property (rsp_q.done && !rsp_q.ack);
  c_fault: cover property ($rose(fault_flag_q) ##[1:20] $fell(fault_flag_q));

endmodule

// ---- dv/scr_engine_model.sv ----
module scr_engine_model (
  // Clock
  input  wire logic        clock,
  // Register port
  output scr_pkg::scr_req_t req,
  input  scr_pkg::scr_rsp_t rsp_q,
  // Address query
  output logic             match_stb,
  output logic       [6:0] match_addr,
  input  wire logic        addr_match_q
);
  timeunit 1ns;
  timeprecision 100ps;
  import scr_pkg::*;

  // Idle bus engine
  initial begin
    req = '0;
    match_stb = 1'b0;
    match_addr = 7'h00;
  end

  // One byte access, answer taken the cycle after the request
  task automatic access(input logic wr, input logic [7:0] off, input logic [7:0] wd,
                        output scr_rsp_t r);
    @(posedge clock);
    #1;
    req = '{wr: wr, rd: !wr, off: off, wdata: wd};
    @(posedge clock);
    #1;
    r = rsp_q;
    req = '0;
  endtask

  // Address query, used to see which address is live
  task automatic query(input logic [6:0] a, output logic m);
    @(posedge clock);
    #1;
    match_stb = 1'b1;
    match_addr = a;
    @(posedge clock);
    #1;
    m = addr_match_q;
    match_stb = 1'b0;
  endtask
endmodule

// ---- dv/sensor_i2c_config_registers_bench.sv ----
module sensor_i2c_config_registers_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import scr_pkg::*;

  logic               clock;
  logic               rstn;
  scr_req_t           req;
  scr_rsp_t           rsp_q;
  scr_rsp_t           r;
  logic               match_stb;
  logic               addr_match_q;
  logic               m;
  logic         [6:0] match_addr;
  logic         [6:0] live_address_q;
  logic         [7:0] config_q;
  logic         [7:0] pressure_unit_q;
  logic         [7:0] temperature_unit_q;
  logic         [7:0] ep;
  logic         [7:0] et;
  logic               fault_flag_q;
  logic signed [31:0] p_lo;
  logic signed [31:0] p_hi;
  logic signed [31:0] t_lo;
  logic signed [31:0] t_hi;
  logic signed [31:0] hv [6] = '{3276, 3277, 327670, 327671, 0, 327670001};
  logic signed [31:0] lv [6] = '{0, 0, 0, 0, 32'h8000_0000, 0};
  logic         [7:0] dv [6] = '{8'h05, 8'h04, 8'h03, 8'h02, 8'hFF, 8'hFF};
  int                 failures = 0;
  int                 comparisons = 0;
  int                 cycles = 0;

  scr_config_regs DUT (.clock(clock), .rstn(rstn), .req(req), .rsp_q(rsp_q),
    .match_stb(match_stb), .match_addr(match_addr), .addr_match_q(addr_match_q),
    .p_range_lo(p_lo), .p_range_hi(p_hi), .t_range_lo(t_lo), .t_range_hi(t_hi),
    .live_address_q(live_address_q), .config_q(config_q), .pressure_unit_q(pressure_unit_q),
    .temperature_unit_q(temperature_unit_q), .fault_flag_q(fault_flag_q));

  scr_engine_model eng (.clock(clock), .req(req), .rsp_q(rsp_q), .match_stb(match_stb),
    .match_addr(match_addr), .addr_match_q(addr_match_q));

  // Valid pressure codes
  function automatic logic pv(input logic [7:0] c);
    return (c >= 8'h01 && c <= 8'h0E) || c == 8'h91 || (c >= 8'hAA && c <= 8'hAE) ||
           (c >= 8'hB0 && c <= 8'hB3) || (c >= 8'hED && c <= 8'hEF);
  endfunction

  // Compare one value
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict
  task automatic tally_and_finish();
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    {p_lo, p_hi, t_lo, t_hi} = '0;
    repeat (20) @(posedge clock);
    #1;
    rstn = 1'b1;
    check(pressure_unit_q, 8'h07);
    check(temperature_unit_q, 8'h20);
    check(fault_flag_q, 8'h00);
    eng.access(1'b0, 8'h43, 8'h00, r);
    check(r.rdata, 8'h50);
    // Every code into both unit registers
    ep = 8'h07;
    et = 8'h20;
    for (int i = 0; i < 256; i++) begin
      eng.access(1'b1, 8'h44, i[7:0], r);
      check(r.ack, pv(i[7:0]));
      if (pv(i[7:0])) ep = i[7:0];
      check(pressure_unit_q, ep);
      eng.access(1'b1, 8'h4D, i[7:0], r);
      check(r.ack, i >= 8'h20 && i <= 8'h23);
      if (i >= 8'h20 && i <= 8'h23) et = i[7:0];
      check(temperature_unit_q, et);
    end
    eng.access(1'b0, 8'h44, 8'h00, r);
    check(r.rdata, ep);
    eng.access(1'b0, 8'h4D, 8'h00, r);
    check(r.rdata, et);
    // Address change waits for the apply bit
    eng.access(1'b1, 8'h43, 8'hA2, r);
    check(r.ack, 8'h01);
    eng.query(7'h28, m);
    check(m, 8'h01);
    eng.query(7'h51, m);
    check(m, 8'h00);
    eng.access(1'b1, 8'h40, 8'h00, r);
    check(live_address_q, 7'h28);
    eng.access(1'b1, 8'h40, 8'h80, r);
    check(live_address_q, 7'h51);
    check(config_q, 8'h00);
    eng.query(7'h51, m);
    check(m, 8'h01);
    eng.query(7'h28, m);
    check(m, 8'h00);
    // Unmapped and read-only places
    eng.access(1'b0, 8'h00, 8'h00, r);
    check(r.done, 8'h01);
    check(r.ack, 8'h00);
    check(r.rdata, 8'h00);
    eng.access(1'b1, 8'h47, 8'h03, r);
    check(r.ack, 8'h00);
    // Fraction digits in integer mode, the last two ranges cannot be shown
    eng.access(1'b1, 8'h40, 8'h01, r);
    check(config_q, 8'h01);
    for (int k = 0; k < 6; k++) begin
      p_hi = hv[k];
      p_lo = lv[k];
      t_lo = -hv[k];
      t_hi = lv[k];
      repeat (3) @(posedge clock);
      eng.access(1'b0, 8'h47, 8'h00, r);
      check(r.rdata, dv[k]);
      eng.access(1'b0, 8'h50, 8'h00, r);
      check(r.rdata, dv[k]);
      check(fault_flag_q, dv[k] == 8'hFF);
    end
    // Float mode hides the fault; integer mode brings it back until the range is fixed
    eng.access(1'b1, 8'h40, 8'h00, r);
    eng.access(1'b0, 8'h40, 8'h00, r);
    check(r.rdata, 8'h00);
    check(fault_flag_q, 8'h00);
    eng.access(1'b1, 8'h40, 8'h01, r);
    eng.access(1'b0, 8'h40, 8'h00, r);
    check(r.rdata, 8'h01);
    check(fault_flag_q, 8'h01);
    {p_lo, p_hi, t_lo, t_hi} = '0;
    repeat (3) @(posedge clock);
    eng.access(1'b0, 8'h47, 8'h00, r);
    check(r.rdata, 8'h05);
    check(fault_flag_q, 8'h00);
    tally_and_finish();
  end
endmodule
